// ==== hdl/adc_frontend_clock_control.sv ====
`timescale 1ns/1ps
// Behaviour
// - Analog clock is system clock over divider plus one; modulator is that over 64.
// - One result per decimation-ratio count of modulator clock periods.
// - Offset trim is sign-magnitude: bit 7 sign, bits 6..0 magnitude.
// - Multiplexer code all ones connects temperature diodes, opens all channels.
// - Any input pair may be positive and negative, including swapped polarity.
// - Burnout bit enables source on positive and sink on negative input.
// - Buffer bit in control register switches the input buffer in or out.
// - Gain setting picks one of eight powers of two, 1 to 128.
module adc_frontend_clock_control
  import adc_frontend_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  // Register bus
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic                  i_sfr_wr,
  input  wire logic                  i_sfr_rd,
  input  wire logic [7:0]            i_sfr_wdata,
  output logic      [7:0]            o_sfr_rdata,
  // Analog front end controls
  output logic [NUM_INPUTS-1:0]      o_pos_sel,
  output logic [NUM_INPUTS-1:0]      o_neg_sel,
  output logic                       o_temp_diode_en,
  output logic                       o_burnout_detect_enable,
  output logic                       o_buffer_en,
  output logic [GAIN_W-1:0]          o_gain_amplifier_setting,
  output logic                       o_trim_sign,
  output logic [TRIM_MAG_W-1:0]      o_trim_magnitude,
  // Clock chain ticks
  output logic                       o_aclk_tick,
  output logic                       o_mod_tick,
  output logic                       o_data_tick
);
  typedef struct packed {
    logic [7:0]            ctrl;
    logic [7:0]            trim;
    logic [7:0]            div;
    logic [7:0]            mux;
    logic [DEC_W-1:0]      dec;
    logic                  ready;
    logic [7:0]            rdata;
    logic [NUM_INPUTS-1:0] pos;
    logic [NUM_INPUTS-1:0] neg;
    logic                  temp;
  } fe_state_t;

  fe_state_t st_q;
  fe_state_t st_d;

  logic [NUM_INPUTS-1:0] pos_dec;
  logic [NUM_INPUTS-1:0] neg_dec;
  logic [DEC_W-1:0]      dec_reload;
  logic                  aclk_tick;
  logic                  mod_tick;
  logic                  data_tick;

  // One-hot channel decode of the written code
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_sel
    assign pos_dec[i] = (i_sfr_wdata != MUX_TEMP_CODE) &&
      (i_sfr_wdata[MUX_POS_LSB +: MUX_FIELD_W] == MUX_FIELD_W'(i));
    assign neg_dec[i] = (i_sfr_wdata != MUX_TEMP_CODE) &&
      (i_sfr_wdata[MUX_NEG_LSB +: MUX_FIELD_W] == MUX_FIELD_W'(i));
  end

  // Ratio zero behaves as ratio one
  assign dec_reload = (st_q.dec == '0) ? '0 : st_q.dec - 1'b1;

  always_comb begin
    st_d       = st_q;
    st_d.rdata = st_q.rdata;
    if (i_sfr_rd) begin
      if (i_sfr_addr == CTRL_ZERO_ADDR) begin
        st_d.rdata = st_q.ctrl;
      end else if (i_sfr_addr == TRIM_ADDR) begin
        st_d.rdata = st_q.trim;
      end else if (i_sfr_addr == ACLK_DIV_ADDR) begin
        st_d.rdata = st_q.div;
      end else if (i_sfr_addr == MUX_ADDR) begin
        st_d.rdata = st_q.mux;
      end else if (i_sfr_addr == DEC_LO_ADDR) begin
        st_d.rdata = st_q.dec[7:0];
      end else if (i_sfr_addr == DEC_HI_ADDR) begin
        st_d.rdata = st_q.dec[15:8];
      end else if (i_sfr_addr == STATUS_ADDR) begin
        st_d.rdata = {7'h00, st_q.ready};
        st_d.ready = 1'b0;
      end else begin
        st_d.rdata = 8'h00;
      end
    end
    if (i_sfr_wr) begin
      if (i_sfr_addr == CTRL_ZERO_ADDR) begin
        st_d.ctrl = i_sfr_wdata;
      end else if (i_sfr_addr == TRIM_ADDR) begin
        st_d.trim = i_sfr_wdata;
      end else if (i_sfr_addr == ACLK_DIV_ADDR) begin
        st_d.div = i_sfr_wdata;
      end else if (i_sfr_addr == MUX_ADDR) begin
        st_d.mux  = i_sfr_wdata;
        st_d.temp = (i_sfr_wdata == MUX_TEMP_CODE);
        st_d.pos  = pos_dec;
        st_d.neg  = neg_dec;
      end else if (i_sfr_addr == DEC_LO_ADDR) begin
        st_d.dec[7:0] = i_sfr_wdata;
      end else if (i_sfr_addr == DEC_HI_ADDR) begin
        st_d.dec[15:8] = i_sfr_wdata;
      end
    end
    // New result beats a clearing read
    if (data_tick) begin
      st_d.ready = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q       <= '0;
      st_q.ctrl  <= CTRL_RESET;
      st_q.trim  <= TRIM_RESET;
      st_q.div   <= DIV_RESET;
      st_q.mux   <= MUX_RESET;
      st_q.dec   <= DEC_RESET;
      st_q.neg   <= NUM_INPUTS'(1) << 1;
      st_q.pos   <= NUM_INPUTS'(1);
    end else begin
      st_q <= st_d;
    end
  end

  // Analog clock from system clock
  clk_tick_divider #(.W(DIV_W)) u_aclk_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_step    (1'b1),
    .i_reload  (st_q.div),
    .o_tick    (aclk_tick)
  );

  // Modulator clock, fixed factor
  clk_tick_divider #(.W(MOD_W)) u_mod_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_step    (aclk_tick),
    .i_reload  (MOD_W'(MOD_FACTOR - 1)),
    .o_tick    (mod_tick)
  );

  // Output word rate
  clk_tick_divider #(.W(DEC_W)) u_data_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_step    (mod_tick),
    .i_reload  (dec_reload),
    .o_tick    (data_tick)
  );

  assign o_sfr_rdata              = st_q.rdata;
  assign o_pos_sel                = st_q.pos;
  assign o_neg_sel                = st_q.neg;
  assign o_temp_diode_en          = st_q.temp;
  assign o_burnout_detect_enable  = st_q.ctrl[BURNOUT_BIT];
  assign o_buffer_en              = st_q.ctrl[BUFFER_BIT];
  assign o_gain_amplifier_setting = st_q.ctrl[GAIN_LSB +: GAIN_W];
  assign o_trim_sign              = st_q.trim[TRIM_SIGN_BIT];
  assign o_trim_magnitude         = st_q.trim[TRIM_MAG_W-1:0];
  assign o_aclk_tick              = aclk_tick;
  assign o_mod_tick               = mod_tick;
  assign o_data_tick              = data_tick;

  // Checking helpers
  logic [8:0]  gap_q;
  logic [7:0]  div_prev_q;
  logic [7:0]  div_lat_q;
  logic        aclk_seen_q;
  logic [6:0]  acnt_q;
  logic        mod_seen_q;
  logic [16:0] mcnt_q;
  logic        data_seen_q;
  logic        dec_wr_q;
  logic        dec_wr_p;
  logic        dec_wr;

  assign dec_wr = i_sfr_wr &&
    (i_sfr_addr == DEC_LO_ADDR || i_sfr_addr == DEC_HI_ADDR);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gap_q <= '0;
      div_prev_q <= '0;
      div_lat_q <= '0;
      aclk_seen_q <= 1'b0;
      acnt_q <= '0;
      mod_seen_q <= 1'b0;
      mcnt_q <= '0;
      data_seen_q <= 1'b0;
      dec_wr_q <= 1'b0;
      dec_wr_p <= 1'b0;
    end else begin
      div_prev_q <= st_q.div;
      gap_q <= aclk_tick ? 9'h001 : gap_q + 9'h001;
      if (aclk_tick) begin
        div_lat_q <= div_prev_q;
        aclk_seen_q <= 1'b1;
      end
      if (mod_tick) begin
        acnt_q <= {6'h00, aclk_tick};
        mod_seen_q <= 1'b1;
      end else if (aclk_tick) begin
        acnt_q <= acnt_q + 7'h01;
      end
      if (data_tick) begin
        mcnt_q <= {16'h0000, mod_tick};
        data_seen_q <= 1'b1;
      end else if (mod_tick) begin
        mcnt_q <= mcnt_q + 17'h00001;
      end
      // A write just before a tick misses the next interval, which still runs on the old ratio
      dec_wr_p <= dec_wr;
      dec_wr_q <= dec_wr || (dec_wr_q && (!data_tick || dec_wr_p));
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  aclk_period_a: assert property (
    aclk_tick && aclk_seen_q |-> gap_q == {1'b0, div_lat_q} + 9'h001)
    else $error("analog clock period differs from divider plus one");

  mod_period_a: assert property (
    mod_tick && mod_seen_q |-> acnt_q == 7'(MOD_FACTOR))
    else $error("modulator tick not every 64 analog ticks");

  data_rate_a: assert property (
    data_tick && data_seen_q && !dec_wr_q && !dec_wr |->
      mcnt_q == ((st_q.dec == '0) ? 17'h00001 : {1'b0, st_q.dec}))
    else $error("result rate does not follow decimation ratio");

  trim_code_a: assert property (
    i_sfr_wr && i_sfr_addr == TRIM_ADDR |=>
      o_trim_sign == $past(i_sfr_wdata[7]) &&
      o_trim_magnitude == $past(i_sfr_wdata[6:0]))
    else $error("offset trim fields wrong after write");

  temp_sensor_a: assert property (
    i_sfr_wr && i_sfr_addr == MUX_ADDR && i_sfr_wdata == 8'hff |=>
      o_temp_diode_en && o_pos_sel == '0 && o_neg_sel == '0)
    else $error("temperature code did not isolate channels");

  channel_pair_a: assert property (
    i_sfr_wr && i_sfr_addr == MUX_ADDR && !i_sfr_wdata[7] &&
      !i_sfr_wdata[3] |=>
      o_pos_sel == (8'h01 << $past(i_sfr_wdata[6:4])) &&
      o_neg_sel == (8'h01 << $past(i_sfr_wdata[2:0])) &&
      !o_temp_diode_en)
    else $error("channel pair selection wrong");

  burnout_bit_a: assert property (
    i_sfr_wr && i_sfr_addr == CTRL_ZERO_ADDR |=>
      o_burnout_detect_enable == $past(i_sfr_wdata[6]))
    else $error("burnout enable does not follow control bit");

  buffer_bit_a: assert property (
    i_sfr_wr && i_sfr_addr == CTRL_ZERO_ADDR |=>
      o_buffer_en == $past(i_sfr_wdata[3]))
    else $error("buffer enable does not follow control bit");

  gain_code_a: assert property (
    i_sfr_wr && i_sfr_addr == CTRL_ZERO_ADDR |=>
      o_gain_amplifier_setting == $past(i_sfr_wdata[2:0]) ##1
      (o_gain_amplifier_setting == $past(i_sfr_wdata[2:0], 2) ||
       ($past(i_sfr_wr) && $past(i_sfr_addr) == CTRL_ZERO_ADDR)))
    else $error("gain setting not held from control write");

  temp_mode_c: cover property (o_temp_diode_en && o_data_tick);
  result_c: cover property (data_tick && data_seen_q);
  div_change_c: cover property (
    aclk_tick && aclk_seen_q && div_lat_q != div_prev_q);
endmodule

// ==== hdl/clk_tick_divider.sv ====
`timescale 1ns/1ps
module clk_tick_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // Step and reload
  input  wire logic         i_step,
  input  wire logic [W-1:0] i_reload,
  // Terminal tick
  output logic              o_tick
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } div_state_t;

  div_state_t st_q;
  div_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (i_step) begin
      if (st_q.count == '0) begin
        st_d.count = i_reload;
        st_d.tick  = 1'b1;
      end else begin
        st_d.count = st_q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule

// ==== include/adc_frontend_pkg.sv ====
package adc_frontend_pkg;
  // Register offsets on the core's register bus
  localparam logic [7:0] CTRL_ZERO_ADDR = 8'hdc;
  localparam logic [7:0] TRIM_ADDR      = 8'he6;
  localparam logic [7:0] ACLK_DIV_ADDR  = 8'hf6;
  localparam logic [7:0] MUX_ADDR       = 8'hd7;
  localparam logic [7:0] DEC_LO_ADDR    = 8'hd8;
  localparam logic [7:0] DEC_HI_ADDR    = 8'hd9;
  localparam logic [7:0] STATUS_ADDR    = 8'hda;
  // Control register fields
  localparam int BURNOUT_BIT = 6;
  localparam int BUFFER_BIT  = 3;
  localparam int GAIN_LSB    = 0;
  localparam int GAIN_W      = 3;
  // Offset trim fields
  localparam int TRIM_SIGN_BIT = 7;
  localparam int TRIM_MAG_W    = 7;
  // Multiplexer fields
  localparam int MUX_POS_LSB  = 4;
  localparam int MUX_NEG_LSB  = 0;
  localparam int MUX_FIELD_W  = 4;
  localparam int NUM_INPUTS   = 8;
  localparam logic [7:0] MUX_TEMP_CODE = 8'hff;
  // Status fields
  localparam int STAT_READY_BIT = 0;
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  TRIM_RESET  = 8'h00;
  localparam logic [7:0]  DIV_RESET   = 8'h00;
  localparam logic [7:0]  MUX_RESET   = 8'h01;
  localparam logic [15:0] DEC_RESET   = 16'h0100;
  // Clock chain
  localparam int DIV_W       = 8;
  localparam int MOD_W       = 6;
  localparam int MOD_FACTOR  = 64;
  localparam int DEC_W       = 16;
endpackage

// ==== verif/sfr_core_model.sv ====
`timescale 1ns/1ps
module sfr_core_model
  import adc_frontend_pkg::*;
(
  // Clock
  input  wire logic       i_clk_sys,
  // Register bus
  output logic      [7:0] o_sfr_addr,
  output logic            o_sfr_wr,
  output logic            o_sfr_rd,
  output logic      [7:0] o_sfr_wdata
);
  initial begin
    o_sfr_addr  = 8'h00;
    o_sfr_wr    = 1'b0;
    o_sfr_rd    = 1'b0;
    o_sfr_wdata = 8'h00;
  end
  // Write; buffer forced on whenever burnout is on
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_sfr_addr  <= a;
    o_sfr_wdata <= (a == CTRL_ZERO_ADDR && d[BURNOUT_BIT]) ?
                   (d | (8'h01 << BUFFER_BIT)) : d;
    o_sfr_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_sfr_wr    <= 1'b0;
    o_sfr_addr  <= ~a;
    o_sfr_wdata <= ~d;
  endtask
  // Read; data taken by the watcher
  task automatic sfr_read(input logic [7:0] a);
    @(posedge i_clk_sys);
    o_sfr_addr <= a;
    o_sfr_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_sfr_rd   <= 1'b0;
    o_sfr_addr <= ~a;
  endtask
endmodule

// ==== verif/tb_adc_frontend_clock_control.sv ====
`timescale 1ns/1ps
module tb_adc_frontend_clock_control;
  import adc_frontend_pkg::*;
  logic              clk;
  logic              rst;
  logic        [7:0] addr;
  logic              wr;
  logic              rd_s;
  logic        [7:0] wdata;
  logic        [7:0] rdata;
  logic        [7:0] pos_sel;
  logic        [7:0] neg_sel;
  logic              temp;
  logic              burnout;
  logic              buf_en;
  logic        [2:0] gain;
  logic              sign;
  logic        [6:0] mag;
  logic        [2:0] ticks;
  logic              rd_seen = 1'b0;
  logic       [15:0] exp_q[$];
  int                errors;
  int                cmp_count;
  int                cycles;

  sfr_core_model i_sfr_core_model (
    .i_clk_sys   (clk),
    .o_sfr_addr  (addr),
    .o_sfr_wr    (wr),
    .o_sfr_rd    (rd_s),
    .o_sfr_wdata (wdata)
  );

  adc_frontend_clock_control i_adc_frontend_clock_control (
    .i_clk_sys                (clk),
    .i_rst                    (rst),
    .i_sfr_addr               (addr),
    .i_sfr_wr                 (wr),
    .i_sfr_rd                 (rd_s),
    .i_sfr_wdata              (wdata),
    .o_sfr_rdata              (rdata),
    .o_pos_sel                (pos_sel),
    .o_neg_sel                (neg_sel),
    .o_temp_diode_en          (temp),
    .o_burnout_detect_enable  (burnout),
    .o_buffer_en              (buf_en),
    .o_gain_amplifier_setting (gain),
    .o_trim_sign              (sign),
    .o_trim_magnitude         (mag),
    .o_aclk_tick              (ticks[0]),
    .o_mod_tick               (ticks[1]),
    .o_data_tick              (ticks[2])
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_val(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_per(string n, int e, int g);
    cmp_count++;
    if (g != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    i_sfr_core_model.sfr_read(a);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // Cycles between the second and third tick of one chain stage
  task automatic per(input int s, input int e, input string nm);
    int c;
    int len;
    c = 0;
    len = 0;
    while (c < 3) begin
      @(posedge clk);
      #1;
      if (c == 2) len++;
      if (ticks[s] === 1'b1) c++;
    end
    chk_per(nm, e, len);
  endtask

  // Read data watcher
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0)
      chk_val("rdata", exp_q.pop_front(), {8'h00, rdata});
    rd_seen <= rd_s;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    logic [7:0] v;
    logic [7:0] e;
    logic [7:0] d;
    rst = 1'b1;
    void'($urandom(32'hdde057fe));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped read
    rd(CTRL_ZERO_ADDR, CTRL_RESET);
    rd(TRIM_ADDR, TRIM_RESET);
    rd(ACLK_DIV_ADDR, DIV_RESET);
    rd(MUX_ADDR, MUX_RESET);
    rd(8'h00, 8'h00);
    // Every gain code with random control bits
    for (int g = 0; g < 8; g++) begin
      v = 8'($urandom);
      v[2:0] = 3'(g);
      e = v;
      if (v[6]) e[3] = 1'b1;
      i_sfr_core_model.sfr_write(CTRL_ZERO_ADDR, v);
      settle();
      chk_val("gain", 16'(g), {13'h0, gain});
      chk_val("burnout", {15'h0, v[6]}, {15'h0, burnout});
      chk_val("buffer", {15'h0, e[3]}, {15'h0, buf_en});
      rd(CTRL_ZERO_ADDR, e);
    end
    // Offset trim fields
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      i_sfr_core_model.sfr_write(TRIM_ADDR, v);
      settle();
      chk_val("trim", {8'h00, v}, {8'h00, sign, mag});
    end
    // Every input pairing, swapped and same included
    for (int p = 0; p < 8; p++) begin
      for (int n = 0; n < 8; n++) begin
        i_sfr_core_model.sfr_write(MUX_ADDR, {4'(p), 4'(n)});
        settle();
        chk_val("sel", {8'h01 << p, 8'h01 << n}, {pos_sel, neg_sel});
      end
    end
    i_sfr_core_model.sfr_write(MUX_ADDR, MUX_TEMP_CODE);
    settle();
    chk_val("temp", 16'h0001, {7'h0, pos_sel, temp});
    chk_val("neg_sel", 16'h0000, {8'h00, neg_sel});
    // Clock chain with ratio 2 and random dividers
    i_sfr_core_model.sfr_write(DEC_HI_ADDR, 8'h00);
    i_sfr_core_model.sfr_write(DEC_LO_ADDR, 8'h02);
    // Let the interval begun at reset finish with the old ratio
    while (ticks[2] !== 1'b1) settle();
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom_range(3, 0));
      i_sfr_core_model.sfr_write(ACLK_DIV_ADDR, d);
      per(0, int'(d) + 1, "aclk");
      per(1, 64 * (int'(d) + 1), "mod");
      per(2, 128 * (int'(d) + 1), "data");
    end
    // Sticky ready set by the last result, cleared by its read
    rd(STATUS_ADDR, 8'h01);
    rd(STATUS_ADDR, 8'h00);
    rd(DEC_LO_ADDR, 8'h02);
    rd(DEC_HI_ADDR, 8'h00);
    rd(ACLK_DIV_ADDR, d);
    rd(TRIM_ADDR, v);
    rd(MUX_ADDR, MUX_TEMP_CODE);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
